/* File: rtl/device_serial_number_capability.sv */
// Device serial number extended capability behind the config access port.
`timescale 1ns/1ps
`include "dsn_cap_defines.svh"

module device_serial_number_capability
   import dsn_cap_pkg::*;
#(
   parameter bit CAP_PRESENT = 1'b1,
   parameter int FUNC_COUNT = 8,
   parameter logic [7:0] FUNC_MASK = 8'h01,
   parameter logic [11:0] CAP_BASE = 12'h100,
   parameter logic [11:0] NEXT_PTR = 12'h000
)
(
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   // Configuration access from the host config logic.
   input wire cfg_req_t cfg_req_i,
   output cfg_rsp_t cfg_rsp_o,
   // Serial number straps.
   input wire logic [23:0] company_id_i,
   input wire logic [39:0] ext_id_i,
   // Shared number for the other devices of the component.
   output dev_serial_t dev_serial_o,
   output logic serial_valid_o
);

   // -----------------------------------------------------------------------
   // Fixed header.
   // -----------------------------------------------------------------------
   logic [11:0] next_ptr;
   logic [31:0] hdr_value;
   logic [FUNC_COUNT-1:0] impl;

   // A misplaced pointer into the legacy space would send software
   // walking through the wrong structures, so it ends the list instead.
   assign next_ptr = (NEXT_PTR > `DSN_NEXT_MIN) ?
                     {NEXT_PTR[11:2], 2'b00} : `DSN_NEXT_END; // RULE_08

   always_comb begin
      hdr_value = 32'h0000_0000;
      hdr_value[`DSN_ID_MSB:`DSN_ID_LSB] = `DSN_CAP_ID; // RULE_06
      hdr_value[`DSN_VER_MSB:`DSN_VER_LSB] = `DSN_CAP_VER; // RULE_07
      hdr_value[`DSN_NEXT_MSB:`DSN_NEXT_LSB] = next_ptr; // RULE_08
   end

   // -----------------------------------------------------------------------
   // Which functions carry the capability.
   // -----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < FUNC_COUNT; g = g + 1) begin : g_impl
         if (g == 0) begin : g_f0
            assign impl[g] = CAP_PRESENT; // RULE_03
         end else begin : g_fn
            assign impl[g] = CAP_PRESENT && FUNC_MASK[g]; // RULE_01
         end
      end
   endgenerate

   function automatic cap_sel_t decode_sel(input logic [11:0] addr);
      logic [11:0] rel;
      rel = addr - CAP_BASE;
      if (addr < CAP_BASE) begin
         decode_sel = SEL_NONE;
      end else if ({rel[11:2], 2'b00} == `DSN_HDR_OFS) begin
         decode_sel = SEL_HDR;
      end else if ({rel[11:2], 2'b00} == `DSN_SN_LO_OFS) begin
         decode_sel = SEL_SN_LO; // RULE_09
      end else if ({rel[11:2], 2'b00} == `DSN_SN_HI_OFS) begin
         decode_sel = SEL_SN_HI; // RULE_09
      end else begin
         decode_sel = SEL_NONE;
      end
   endfunction

   function automatic logic func_has_cap(input logic [2:0] func);
      if (int'(func) >= FUNC_COUNT) begin
         func_has_cap = 1'b0;
      end else begin
         func_has_cap = impl[func];
      end
   endfunction

   // -----------------------------------------------------------------------
   // Serial number source.
   // -----------------------------------------------------------------------
   // One latch serves every function, so all of them read one value.
   serial_id_latch u_latch (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .company_id_i(company_id_i),
      .ext_id_i(ext_id_i),
      .serial_o(dev_serial_o), // RULE_05
      .valid_o(serial_valid_o)
   );

   // -----------------------------------------------------------------------
   // Read mux.
   // -----------------------------------------------------------------------
   cap_sel_t sel;
   logic take;
   logic [31:0] next_rdata;

   assign sel = decode_sel(cfg_req_i.addr);
   assign take = cfg_req_i.valid && func_has_cap(cfg_req_i.func) &&
                 (sel != SEL_NONE);

   always_comb begin
      next_rdata = `DSN_DATA_RST;
      if (take && !cfg_req_i.write) begin // RULE_11
         case (sel)
            SEL_HDR: begin
               next_rdata = hdr_value;
            end
            SEL_SN_LO: begin
               next_rdata = dev_serial_o[31:0]; // RULE_04
            end
            SEL_SN_HI: begin
               next_rdata = dev_serial_o[63:32]; // RULE_04
            end
            default: begin
               next_rdata = `DSN_DATA_RST;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------------
   // Response register.
   // -----------------------------------------------------------------------
   // Writes are acknowledged so the config logic never stalls, but no
   // storage exists behind them; the structure stays read-only.
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cfg_rsp_o.ack <= 1'b0;
         cfg_rsp_o.hit <= 1'b0;
         cfg_rsp_o.rdata <= `DSN_DATA_RST;
      end else begin
         cfg_rsp_o.ack <= cfg_req_i.valid;
         cfg_rsp_o.hit <= take;
         cfg_rsp_o.rdata <= next_rdata; // RULE_02
      end
   end

   // -----------------------------------------------------------------------
   // Assertions.
   // -----------------------------------------------------------------------
   default clocking @(posedge sys_clk_i);
   endclocking

   default disable iff (!rstn_i);

   logic rd_ok;
   assign rd_ok = cfg_req_i.valid && !cfg_req_i.write &&
                  func_has_cap(cfg_req_i.func);

   property p_absent;
      cfg_req_i.valid && !func_has_cap(cfg_req_i.func)
      |=> cfg_rsp_o.ack && !cfg_rsp_o.hit;
   endproperty
   a_absent: assert property (p_absent) // RULE_01
      else $error("function without the capability claimed an access");

   property p_serial_fixed;
      serial_valid_o |=> serial_valid_o && $stable(dev_serial_o);
   endproperty
   a_serial_fixed: assert property (p_serial_fixed) // RULE_02
      else $error("serial number changed after it was latched");

   property p_func0_hdr;
      cfg_req_i.valid && !cfg_req_i.write && cfg_req_i.func == 3'h0 &&
      sel == SEL_HDR && CAP_PRESENT
      |=> cfg_rsp_o.hit && cfg_rsp_o.rdata == hdr_value;
   endproperty
   a_func0_hdr: assert property (p_func0_hdr) // RULE_03
      else $error("function 0 did not return the header");

   property p_same_lo;
      rd_ok && sel == SEL_SN_LO && serial_valid_o
      |=> cfg_rsp_o.hit && cfg_rsp_o.rdata == dev_serial_o[31:0];
   endproperty
   a_same_lo: assert property (p_same_lo) // RULE_04
      else $error("function returned a different low serial dword");

   property p_shared_hi;
      rd_ok && sel == SEL_SN_HI && serial_valid_o
      |=> cfg_rsp_o.rdata == dev_serial_o[63:32];
   endproperty
   a_shared_hi: assert property (p_shared_hi) // RULE_05
      else $error("high dword differs from the shared serial number");

   property p_cap_id;
      rd_ok && sel == SEL_HDR
      |=> cfg_rsp_o.rdata[15:0] == 16'h0003;
   endproperty
   a_cap_id: assert property (p_cap_id) // RULE_06
      else $error("capability identifier is not 0003h");

   property p_cap_ver;
      rd_ok && sel == SEL_HDR
      ##1 cfg_rsp_o.ack |-> cfg_rsp_o.rdata[19:16] == 4'h1;
   endproperty
   a_cap_ver: assert property (p_cap_ver) // RULE_07
      else $error("capability version is not 1h");

   property p_next_ptr;
      rd_ok && sel == SEL_HDR
      |=> (cfg_rsp_o.rdata[31:20] == 12'h000 ||
           cfg_rsp_o.rdata[31:20] > 12'h0ff) &&
          cfg_rsp_o.rdata[21:20] == 2'b00;
   endproperty
   a_next_ptr: assert property (p_next_ptr) // RULE_08
      else $error("next capability pointer lies in the legacy space");

   property p_offsets;
      cfg_req_i.valid && !cfg_req_i.write && func_has_cap(cfg_req_i.func) &&
      cfg_req_i.addr == CAP_BASE + 12'h004 && serial_valid_o
      |=> cfg_rsp_o.rdata == $past(dev_serial_o[31:0]);
   endproperty
   a_offsets: assert property (p_offsets) // RULE_09
      else $error("offset 04h does not hold serial bits 31:0");

   property p_compose;
      $rose(serial_valid_o) |->
         dev_serial_o.company == $past(company_id_i, 3) &&
         dev_serial_o.ext == $past(ext_id_i, 3);
   endproperty
   a_compose: assert property (p_compose) // RULE_10
      else $error("serial number is not company id over extension");

   property p_write_ignored;
      cfg_req_i.valid && cfg_req_i.write
      |=> cfg_rsp_o.ack && cfg_rsp_o.rdata == 32'h0000_0000 &&
          $stable(dev_serial_o);
   endproperty
   a_write_ignored: assert property (p_write_ignored) // RULE_11
      else $error("write changed the structure or returned data");

   property p_hdr_stable;
      rd_ok && sel == SEL_HDR ##1 rd_ok && sel == SEL_HDR
      |=> cfg_rsp_o.rdata == $past(cfg_rsp_o.rdata);
   endproperty
   a_hdr_stable: assert property (p_hdr_stable) // RULE_11
      else $error("two header reads returned different values");

   property p_unmapped;
      cfg_req_i.valid && sel == SEL_NONE
      |=> cfg_rsp_o.ack && !cfg_rsp_o.hit &&
          cfg_rsp_o.rdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) // RULE_01
      else $error("access outside the structure was claimed");

endmodule

/* File: rtl/dsn_cap_defines.svh */
// Offsets, field positions, fixed values and timing counts of the block.
//
// Operation
// RULE_01 - The serial number capability is optional and may be left out.
// RULE_02 - The device exposes a read-only 64-bit number unique to it.
// RULE_03 - A multi-function device with the capability has it in function 0.
// RULE_04 - Every other function with it returns function 0's serial number.
// RULE_05 - All devices of one component report one identical serial number.
// RULE_06 - Header bits 15:0 hold the read-only capability identifier 0003h.
// RULE_07 - Header bits 19:16 hold the read-only capability version 1h.
// RULE_08 - Header bits 31:20 point onward, 000h at the end, else above 0FFh.
// RULE_09 - The number sits at offset 04h, bits 31:0 first, then bits 63:32.
// RULE_10 - The number is a 24-bit company id above a 40-bit extension.
// RULE_11 - Writes to the structure are ignored and reads return fixed values.
`ifndef DSN_CAP_DEFINES_SVH
`define DSN_CAP_DEFINES_SVH

// -----------------------------------------------------------------------
// Structure offsets, relative to the capability base.
// -----------------------------------------------------------------------
`define DSN_HDR_OFS 12'h000
`define DSN_SN_LO_OFS 12'h004
`define DSN_SN_HI_OFS 12'h008

// -----------------------------------------------------------------------
// Header fields.
// -----------------------------------------------------------------------
`define DSN_ID_LSB 0
`define DSN_ID_MSB 15
`define DSN_VER_LSB 16
`define DSN_VER_MSB 19
`define DSN_NEXT_LSB 20
`define DSN_NEXT_MSB 31
`define DSN_CAP_ID 16'h0003
`define DSN_CAP_VER 4'h1
`define DSN_NEXT_END 12'h000
`define DSN_NEXT_MIN 12'h0ff

// -----------------------------------------------------------------------
// Serial number layout and reset values.
// -----------------------------------------------------------------------
`define DSN_COMPANY_W 24
`define DSN_EXT_W 40
`define DSN_SERIAL_RST 64'h0000_0000_0000_0000
`define DSN_DATA_RST 32'h0000_0000

// -----------------------------------------------------------------------
// Timing: edges after reset release before the straps are latched.
// -----------------------------------------------------------------------
`define DSN_SETTLE_CYC 2'h2

`endif

/* File: rtl/dsn_cap_pkg.sv */
// Types shared by the serial number capability files.
package dsn_cap_pkg;

   typedef struct packed {
      logic valid;
      logic write;
      logic [2:0] func;
      logic [11:0] addr;
      logic [31:0] wdata;
   } cfg_req_t;

   typedef struct packed {
      logic ack;
      logic hit;
      logic [31:0] rdata;
   } cfg_rsp_t;

   typedef struct packed {
      logic [23:0] company;
      logic [39:0] ext;
   } dev_serial_t;

   typedef enum {SEL_NONE, SEL_HDR, SEL_SN_LO, SEL_SN_HI} cap_sel_t;

   typedef enum {LATCH_SETTLE, LATCH_HELD} latch_state_t;

endpackage

/* File: rtl/serial_id_latch.sv */
// Strap synchroniser and one-time latch for the device serial number.
`timescale 1ns/1ps
`include "dsn_cap_defines.svh"

module serial_id_latch
   import dsn_cap_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   // Strap pins.
   input wire logic [23:0] company_id_i,
   input wire logic [39:0] ext_id_i,
   // Latched number.
   output dev_serial_t serial_o,
   output logic valid_o
);

   dev_serial_t sync1;
   dev_serial_t sync2;
   latch_state_t state;
   logic [1:0] settle;

   // -----------------------------------------------------------------------
   // Two-stage synchroniser.
   // -----------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1 <= `DSN_SERIAL_RST;
         sync2 <= `DSN_SERIAL_RST;
      end else begin
         sync1 <= {company_id_i, ext_id_i};
         sync2 <= sync1;
      end
   end

   // -----------------------------------------------------------------------
   // Latch once after release.
   // -----------------------------------------------------------------------
   // Latching once keeps the number fixed even if a strap glitches later.
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= LATCH_SETTLE;
         settle <= 2'h0;
         serial_o <= `DSN_SERIAL_RST;
         valid_o <= 1'b0;
      end else begin
         case (state)
            LATCH_SETTLE: begin
               if (settle == `DSN_SETTLE_CYC) begin
                  serial_o <= sync2; // RULE_10
                  valid_o <= 1'b1;
                  state <= LATCH_HELD;
               end else begin
                  settle <= settle + 2'h1;
               end
            end
            LATCH_HELD: begin
               state <= LATCH_HELD;
            end
            default: begin
               state <= LATCH_SETTLE;
            end
         endcase
      end
   end

endmodule

/* File: testbench/tb.sv */
// Self-checking testbench of the device serial number capability.
`timescale 1ns/1ps
`include "dsn_cap_defines.svh"

module tb import dsn_cap_pkg::*;;

   // ---------------------------------------------------------------
   // Settings and signals.
   // ---------------------------------------------------------------
   // Function 1 also carries the structure, so sibling reads can be compared.
   localparam logic [11:0] BASE = 12'h100;
   localparam logic [11:0] NPTR = 12'h140;
   localparam logic [23:0] CO_A = 24'habcdef;
   localparam logic [39:0] EX_A = 40'h12_3456_789a;
   localparam logic [23:0] CO_B = 24'h5a0c31;
   localparam logic [39:0] EX_B = 40'hc3_0f1e_2d4b;
   localparam logic [31:0] HDR = {NPTR, `DSN_CAP_VER, `DSN_CAP_ID};

   logic sys_clk_i;
   logic rstn_i;
   cfg_req_t cfg_req_i;
   cfg_rsp_t cfg_rsp_o;
   logic [23:0] company_id_i;
   logic [39:0] ext_id_i;
   dev_serial_t dev_serial_o;
   logic serial_valid_o;
   int miscompares;
   int checks;

   device_serial_number_capability #(
      .CAP_PRESENT(1'b1),
      .FUNC_COUNT(8),
      .FUNC_MASK(8'h03),
      .CAP_BASE(BASE),
      .NEXT_PTR(NPTR)
   ) dut (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .cfg_req_i(cfg_req_i),
      .cfg_rsp_o(cfg_rsp_o),
      .company_id_i(company_id_i),
      .ext_id_i(ext_id_i),
      .dev_serial_o(dev_serial_o),
      .serial_valid_o(serial_valid_o)
   );

   initial begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   // ---------------------------------------------------------------
   // Shared tasks.
   // ---------------------------------------------------------------
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
                      input string what);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: %s seen %h expected %h", $time, what,
                  seen, exp);
      end
   endtask

   // Inputs always change 1 ns after the rising edge.
   task automatic step();
      @(posedge sys_clk_i);
      #1;
   endtask

   // One access; the answer stands in the cycle after the taking edge.
   // Valid stays up afterwards, so calls in a row make back-to-back
   // requests without lowering and raising it in one time step.
   task automatic acc(input logic wr, input logic [2:0] fn,
                      input logic [11:0] ad, input logic hit,
                      input logic [31:0] data);
      cfg_req_i = '{1'b1, wr, fn, ad, 32'hffff_ffff};
      step();
      chk(cfg_rsp_o, {1'b1, hit, data}, "access response");
   endtask

   task automatic conclude();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios.
   // ---------------------------------------------------------------
   // Straps change only while reset is held, as the pins must stay static.
   task automatic t_reset(input logic [23:0] co, input logic [39:0] ex);
      rstn_i = 1'b0;
      company_id_i = co;
      ext_id_i = ex;
      repeat (5) step();
      rstn_i = 1'b1;
      step();
      chk(serial_valid_o, 1'b0, "valid at edge 1");
      chk(dev_serial_o, 64'h0, "serial at edge 1");
      acc(1'b0, 3'h0, BASE, 1'b1, HDR);
      chk(serial_valid_o, 1'b0, "valid at edge 2");
      step();
      chk(serial_valid_o, 1'b1, "valid at edge 3");
      chk(dev_serial_o, {co, ex}, "shared serial");
   endtask

   // Both dwords from function 0 and from the sibling function 1.
   task automatic t_serial(input logic [23:0] co, input logic [39:0] ex);
      for (int f = 0; f < 2; f++) begin
         acc(1'b0, 3'(f), BASE + 12'h004, 1'b1, ex[31:0]);
         acc(1'b0, 3'(f), BASE + 12'h008, 1'b1, {co, ex[39:32]});
      end
      acc(1'b0, 3'h1, BASE, 1'b1, HDR);
      chk(dev_serial_o, {co, ex}, "shared serial");
   endtask

   // Writes of all ones are acknowledged but change nothing.
   task automatic t_write();
      acc(1'b1, 3'h0, BASE, 1'b1, 32'h0);
      acc(1'b1, 3'h0, BASE + 12'h004, 1'b1, 32'h0);
      acc(1'b1, 3'h1, BASE + 12'h008, 1'b1, 32'h0);
      acc(1'b0, 3'h0, BASE, 1'b1, HDR);
      t_serial(CO_A, EX_A);
   endtask

   // Functions without the structure and places outside it give no hit.
   task automatic t_miss();
      acc(1'b0, 3'h2, BASE, 1'b0, 32'h0);
      acc(1'b0, 3'h7, BASE + 12'h004, 1'b0, 32'h0);
      acc(1'b0, 3'h0, BASE + 12'h00c, 1'b0, 32'h0);
      acc(1'b0, 3'h0, BASE - 12'h004, 1'b0, 32'h0);
      acc(1'b0, 3'h0, 12'h000, 1'b0, 32'h0);
   endtask

   // Requests every cycle, high dword first, low address bits ignored.
   task automatic t_b2b();
      logic [11:0] ad [4];
      logic [2:0] fn [4];
      logic [32:0] ex [4];
      ad = '{BASE + 12'h008, BASE + 12'h006, BASE, BASE + 12'h00c};
      fn = '{3'h1, 3'h0, 3'h0, 3'h0};
      ex = '{{1'b1, CO_A, EX_A[39:32]}, {1'b1, EX_A[31:0]}, {1'b1, HDR},
             33'h0};
      for (int i = 0; i < 4; i++) begin
         cfg_req_i = '{1'b1, 1'b0, fn[i], ad[i], 32'h0};
         step();
         chk(cfg_rsp_o, {1'b1, ex[i]}, "back to back");
      end
      cfg_req_i.valid = 1'b0;
      step();
      chk(cfg_rsp_o, 34'h0, "idle response");
   endtask

   // ---------------------------------------------------------------
   // Main sequence and watchdog.
   // ---------------------------------------------------------------
   initial begin
      miscompares = 0;
      checks = 0;
      cfg_req_i = '0;
      t_reset(CO_A, EX_A);
      t_serial(CO_A, EX_A);
      t_write();
      t_miss();
      t_b2b();
      t_reset(CO_B, EX_B);
      t_serial(CO_B, EX_B);
      conclude();
   end

   // The sequence needs about 45 cycles; 2000 leaves a wide margin.
   initial begin
      #(100 * 2000);
      miscompares++;
      $display("Error at %0t: watchdog expired", $time);
      conclude();
   end

endmodule
